// ### dv/sfi_fifo_side.sv
`timescale 1ns/1ps
// ==========================================================
// Receive drain and transmit source model
module sfi_fifo_side (
    // Clock
    input  wire logic        mclk,
    // Receive side
    input  wire logic        rx_valid,
    output logic             rx_ready,
    // Transmit side
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [31:0]      tx_data,
    // Stall mode
    input  wire logic        slow
);
    logic [31:0] txq[$];

    initial begin
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data  = 32'h00000000;
    end

    task automatic put(input logic [31:0] w);
        txq.push_back(w);
    endtask : put

    // Word leaves on handshake; idle data toggles so nothing stale survives
    always @(posedge mclk) begin
        if (tx_valid && tx_ready) begin
            void'(txq.pop_front());
        end
        #1;
        rx_ready = slow ? 1'($urandom % 2) : 1'b1;
        tx_valid = txq.size() != 0;
        tx_data  = tx_valid ? txq[0] : ~tx_data;
    end
endmodule : sfi_fifo_side

// ### dv/tb_shift_fifo_instruction_unit.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: %s", $time, m); end end
module tb_shift_fifo_instruction_unit;
    import sfi_pkg::*;
    // ==========================================================
    // Signals and model state
    logic        mclk, reset, instr_valid, instr_stall, instr_done, in_dir, out_dir;
    logic        apush, apull, load_v, rx_valid, rx_ready, tx_valid, tx_ready, nemp, slow;
    logic        ap, skip, emp;
    logic [15:0] instr;
    logic [4:0]  pth, lth, n5;
    logic [2:0]  sel;
    logic [7:0]  we;
    logic [5:0]  icnt_o, ocnt_o;
    logic [31:0] pins, sx, sy, load_d, wr_data, rx_data, tx_data, in_reg_o, out_reg_o;
    logic [31:0] in_reg, out_reg, d, v, exp_rx[$], txw[$];
    logic [34:0] exp_wr[$], e;
    int          icnt, ocnt, nn, cyc, err_count, check_count;

    sfi_exec_unit DUT (
        .mclk(mclk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
        .instr_stall(instr_stall), .instr_done(instr_done), .in_shift_direction(in_dir),
        .out_shift_direction(out_dir), .auto_push_en(apush), .auto_pull_en(apull),
        .in_push_threshold(pth), .out_pull_threshold(lth), .pin_in(pins), .scratch_x(sx),
        .scratch_y(sy), .osr_load_valid(load_v), .osr_load_data(load_d),
        .out_wr_data(wr_data), .out_dest_we(we), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .input_shift_reg(in_reg_o), .output_shift_reg(out_reg_o), .in_shift_count(icnt_o),
        .out_shift_count(ocnt_o), .out_reg_not_empty_cond(nemp));

    sfi_fifo_side fifo_side (
        .mclk(mclk), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .slow(slow));

    // ==========================================================
    // Helpers
    function automatic int thr(input logic [4:0] t);
        return t == 5'h00 ? 32 : int'(t);
    endfunction : thr

    task automatic summarize;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic run(input logic [15:0] w);
        int n;
        instr = w;
        instr_valid = 1'b1;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (!instr_done && n < 400);
        emp = !tx_valid;
        `CHK(instr_done, 1'b1, "no retire")
        @(posedge mclk);
        #1;
    endtask : run

    task automatic feed;
        logic [31:0] w;
        if (txw.size() == 0) begin
            w = $urandom;
            txw.push_back(w);
            fork
                begin
                    repeat (4) @(posedge mclk);
                    #1;
                    fifo_side.put(w);
                end
            join_none
        end
    endtask : feed

    task automatic push_note;
        exp_rx.push_back(in_reg);
        in_reg = 32'h00000000;
        icnt = 0;
    endtask : push_note

    // ==========================================================
    // Clock, timeout and result monitor
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            summarize();
        end
    end

    always @(negedge mclk) begin
        if (we !== 8'h00) begin
            `CHK(exp_wr.size() != 0, 1'b1, "extra write")
            e = exp_wr.pop_front();
            `CHK(we, 8'h01 << e[34:32], "destination")
            `CHK(wr_data, e[31:0], "written word")
        end
        if (rx_valid && rx_ready) begin
            `CHK(exp_rx.size() != 0, 1'b1, "extra push")
            `CHK(rx_data, exp_rx.pop_front(), "pushed word")
        end
    end

    // ==========================================================
    // Stimulus
    initial begin
        void'($urandom(32'hee58));
        {reset, instr_valid, load_v, in_dir, out_dir, apush, apull, slow} = 8'hFF;
        {instr_valid, load_v} = 2'b00;
        instr = 16'h0000;
        {pth, lth, load_d, sx, sy} = '0;
        pins = $urandom;
        {in_reg, out_reg, icnt, ocnt, cyc, err_count, check_count} = '0;
        ocnt = 32;
        repeat (10) @(posedge mclk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        for (int i = 0; i < 400; i++) begin
            if (i % 50 == 0) begin
                {in_dir, out_dir, apush, apull, slow} = 5'($urandom);
                pth = 5'($urandom);
                lth = 5'($urandom);
            end
            sx = $urandom;
            sy = $urandom;
            n5 = 5'($urandom);
            sel = 3'($urandom);
            nn = n5 == 5'h00 ? 32 : int'(n5);
            if (($urandom % 3) == 0 && txw.size() < 3) begin
                d = $urandom;
                txw.push_back(d);
                fifo_side.put(d);
            end
            case ($urandom % 5)
                0: begin
                    v = sel == SRC_PINS ? pins : sel == SRC_X ? sx : sel == SRC_Y ? sy :
                        sel == SRC_ISR ? in_reg : sel == SRC_OSR ? out_reg : 32'h00000000;
                    run({OPC_IN, 5'h00, sel, n5});
                    v = v & (ALL_ONES >> (32 - nn));
                    in_reg = in_dir ? (in_reg >> nn) | (v << (32 - nn)) : (in_reg << nn) | v;
                    icnt = icnt + nn > 32 ? 32 : icnt + nn;
                    if (apush && icnt >= thr(pth)) push_note();
                end
                1: begin
                    if (apush && sel == DST_ISR) sel = DST_NULL;
                    ap = apull && ocnt >= thr(lth);
                    if (ap) feed();
                    run({OPC_OUT, 5'h00, sel, n5});
                    if (ap) begin
                        out_reg = txw.pop_front();
                        ocnt = 0;
                    end
                    d = out_dir ? out_reg & (ALL_ONES >> (32 - nn)) : out_reg >> (32 - nn);
                    out_reg = out_dir ? out_reg >> nn : out_reg << nn;
                    ocnt = ocnt + nn > 32 ? 32 : ocnt + nn;
                    exp_wr.push_back({sel, d});
                    if (sel == DST_ISR) begin
                        in_reg = d;
                        icnt = nn;
                    end
                end
                2: begin
                    skip = sel[1] && icnt < thr(pth);
                    run({OPC_PUSH_PULL, 5'h00, 1'b0, sel[1], sel[0] | rx_valid, 5'h00});
                    if (!skip) push_note();
                end
                3: begin
                    skip = sel[1] && ocnt < thr(lth);
                    if (!skip && sel[0]) feed();
                    run({OPC_PUSH_PULL, 5'h00, 1'b1, sel[1], sel[0], 5'h00});
                    if (!skip) begin
                        out_reg = emp ? sx : txw.pop_front();
                        ocnt = 0;
                    end
                end
                default: begin
                    instr_valid = 1'b0;
                    load_v = 1'b1;
                    load_d = $urandom;
                    @(posedge mclk);
                    #1;
                    load_v = 1'b0;
                    out_reg = load_d;
                    ocnt = 0;
                end
            endcase
            `CHK(in_reg_o, in_reg, "input register")
            `CHK(out_reg_o, out_reg, "output register")
            `CHK(icnt_o, 6'(icnt), "input count")
            `CHK(ocnt_o, 6'(ocnt), "output count")
            `CHK(nemp, 1'(ocnt < thr(lth)), "not empty flag")
        end
        instr_valid = 1'b0;
        slow = 1'b0;
        repeat (20) @(posedge mclk);
        `CHK(exp_rx.size() + exp_wr.size(), 0, "results missing")
        summarize();
    end
endmodule : tb_shift_fifo_instruction_unit

// ### rtl/sfi_exec_unit.sv
`timescale 1ns/1ps
// Operation
// - Input shift by count, saturate count 32
// - Input source codes, two reserved
// - Count field zero means thirty-two bits
// - Autopush at threshold, still one cycle
// - Autopush stalls when full, clears register
// - Low source bits fill gap unchanged
// - Output shift by count, saturate count 32
// - Output destination codes decoded
// - Written word zero-extended, direction picks bits
// - Autopull refills, clears count, stalls empty
// - Execute destination hands word next cycle
// - Program counter destination jumps unconditionally
// - Push writes word, clears input register
// - Push if-full gated by push threshold
// - Blocking push stalls while buffer full
// - Pull loads one word into output
// - Pull if-empty gated by pull threshold
// - Blocking pull stalls; else copies X
// - Empty non-blocking pull equals move X
// - Move into output register clears count
// - Not-empty compares shifted bits with threshold
module sfi_exec_unit
    import sfi_pkg::*;
(
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       reset,
    // Instruction
    input  wire logic                       instr_valid,
    input  wire logic [sfi_pkg::INSTR_W-1:0] instr,
    output logic                            instr_stall,
    output logic                            instr_done,
    // Configuration
    input  wire logic                       in_shift_direction,
    input  wire logic                       out_shift_direction,
    input  wire logic                       auto_push_en,
    input  wire logic                       auto_pull_en,
    input  wire logic [4:0]                 in_push_threshold,
    input  wire logic [4:0]                 out_pull_threshold,
    // Sources
    input  wire logic [sfi_pkg::WORD_W-1:0] pin_in,
    input  wire logic [sfi_pkg::WORD_W-1:0] scratch_x,
    input  wire logic [sfi_pkg::WORD_W-1:0] scratch_y,
    // Move into output register
    input  wire logic                       osr_load_valid,
    input  wire logic [sfi_pkg::WORD_W-1:0] osr_load_data,
    // Destination writes
    output logic [sfi_pkg::WORD_W-1:0]      out_wr_data,
    output logic [sfi_pkg::DST_NUM-1:0]     out_dest_we,
    // Receive FIFO
    output logic                            rx_valid,
    input  wire logic                       rx_ready,
    output logic [sfi_pkg::WORD_W-1:0]      rx_data,
    // Transmit FIFO
    input  wire logic                       tx_valid,
    output logic                            tx_ready,
    input  wire logic [sfi_pkg::WORD_W-1:0] tx_data,
    // Status
    output logic [sfi_pkg::WORD_W-1:0]      input_shift_reg,
    output logic [sfi_pkg::WORD_W-1:0]      output_shift_reg,
    output logic [5:0]                      in_shift_count,
    output logic [5:0]                      out_shift_count,
    output logic                            out_reg_not_empty_cond
);
    import sfi_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [5:0] field_count(input logic [4:0] f);
        return (f == 5'h00) ? FULL_CNT : {1'b0, f};
    endfunction : field_count

    function automatic logic [31:0] low_mask(input logic [5:0] n);
        return (n == FULL_CNT) ? ALL_ONES : ((32'h00000001 << n) - 32'h00000001);
    endfunction : low_mask

    function automatic logic [5:0] sat_add(input logic [5:0] a, input logic [5:0] b);
        logic [6:0] s;
        s = {1'b0, a} + {1'b0, b};
        return (s > {1'b0, FULL_CNT}) ? FULL_CNT : s[5:0];
    endfunction : sat_add

    logic [WORD_W-1:0]  pin_s1;
    logic [WORD_W-1:0]  pin_s2;
    logic [WORD_W-1:0]  pin_s3;
    logic [WORD_W-1:0]  pin_stable;
    logic [WORD_W-1:0]  next_isr;
    logic [WORD_W-1:0]  next_osr;
    logic [5:0]         next_isr_cnt;
    logic [5:0]         next_osr_cnt;
    logic [WORD_W-1:0]  next_wr_data;
    logic [DST_NUM-1:0] next_dest_we;
    logic [WORD_W-1:0]  src_word;
    logic [WORD_W-1:0]  gap_word;
    logic [WORD_W-1:0]  base_word;
    logic [WORD_W-1:0]  value;
    logic [WORD_W-1:0]  push_data;
    logic [5:0]         n;
    logic [5:0]         sum;
    logic [5:0]         base_cnt;
    logic [5:0]         push_thr;
    logic [5:0]         pull_thr;
    logic [2:0]         opc;
    logic [2:0]         sel;
    logic               pull_hit;
    logic               push_valid;
    logic               push_ready;
    logic               exec_retire;

    // ==========================================================
    // Decode
    assign opc      = instr[OPC_HI:OPC_LO];
    assign sel      = instr[SEL_HI:SEL_LO];
    assign n        = field_count(instr[CNT_HI:CNT_LO]);
    assign push_thr = field_count(in_push_threshold);
    assign pull_thr = field_count(out_pull_threshold);
    assign instr_done = instr_valid && !instr_stall;
    assign exec_retire = instr_done && opc == OPC_OUT && sel == DST_EXEC;
    assign out_reg_not_empty_cond = (out_shift_count < pull_thr);

    // ==========================================================
    // Pin input synchroniser
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_s1     <= ZERO_WORD;
            pin_s2     <= ZERO_WORD;
            pin_s3     <= ZERO_WORD;
            pin_stable <= ZERO_WORD;
        end else begin
            pin_s1     <= pin_in;
            pin_s2     <= pin_s1;
            pin_s3     <= pin_s2;
            pin_stable <= (pin_s2 & pin_s3) | (pin_stable & (pin_s2 | pin_s3));
        end
    end

    // ==========================================================
    // Instruction execution
    always_comb begin
        next_isr     = input_shift_reg;
        next_osr     = output_shift_reg;
        next_isr_cnt = in_shift_count;
        next_osr_cnt = out_shift_count;
        next_wr_data = ZERO_WORD;
        next_dest_we = '0;
        push_valid   = 1'b0;
        push_data    = input_shift_reg;
        tx_ready     = 1'b0;
        instr_stall  = 1'b0;
        src_word     = ZERO_WORD;
        gap_word     = ZERO_WORD;
        base_word    = output_shift_reg;
        base_cnt     = out_shift_count;
        value        = ZERO_WORD;
        sum          = ZERO_CNT;
        pull_hit     = 1'b0;
        if (instr_valid) begin
            case (opc)
                OPC_IN: begin
                    case (sel)
                        SRC_PINS: src_word = pin_stable;
                        SRC_X:    src_word = scratch_x;
                        SRC_Y:    src_word = scratch_y;
                        SRC_ISR:  src_word = input_shift_reg;
                        SRC_OSR:  src_word = output_shift_reg;
                        default:  src_word = ZERO_WORD;
                    endcase
                    if (in_shift_direction) begin
                        gap_word = (input_shift_reg >> n) |
                                   ((src_word & low_mask(n)) << (FULL_CNT - n));
                    end else begin
                        gap_word = (input_shift_reg << n) | (src_word & low_mask(n));
                    end
                    sum = sat_add(in_shift_count, n);
                    if (auto_push_en && sum >= push_thr) begin
                        push_valid = 1'b1;
                        push_data  = gap_word;
                        if (!push_ready) begin
                            instr_stall = 1'b1;
                        end else begin
                            next_isr     = ZERO_WORD;
                            next_isr_cnt = ZERO_CNT;
                        end
                    end else begin
                        next_isr     = gap_word;
                        next_isr_cnt = sum;
                    end
                end
                OPC_OUT: begin
                    pull_hit = auto_pull_en && (out_shift_count >= pull_thr);
                    if (pull_hit) begin
                        base_word = tx_data;
                        base_cnt  = ZERO_CNT;
                    end
                    if (pull_hit && !tx_valid) begin
                        instr_stall = 1'b1;
                    end else begin
                        tx_ready = pull_hit;
                        if (out_shift_direction) begin
                            value    = base_word & low_mask(n);
                            next_osr = base_word >> n;
                        end else begin
                            value    = base_word >> (FULL_CNT - n);
                            next_osr = base_word << n;
                        end
                        next_osr_cnt      = sat_add(base_cnt, n);
                        next_wr_data      = value;
                        next_dest_we[sel] = 1'b1;
                        if (sel == DST_ISR) begin
                            next_isr     = value;
                            next_isr_cnt = n;
                        end
                    end
                end
                OPC_PUSH_PULL: begin
                    if (instr[PP_PULL_BIT]) begin
                        if (instr[PP_IF_BIT] && out_shift_count < pull_thr) begin
                            next_osr = output_shift_reg;
                        end else if (tx_valid) begin
                            tx_ready     = 1'b1;
                            next_osr     = tx_data;
                            next_osr_cnt = ZERO_CNT;
                        end else if (instr[PP_BLK_BIT]) begin
                            instr_stall = 1'b1;
                        end else begin
                            next_osr     = scratch_x;
                            next_osr_cnt = ZERO_CNT;
                        end
                    end else begin
                        if (instr[PP_IF_BIT] && in_shift_count < push_thr) begin
                            next_isr = input_shift_reg;
                        end else begin
                            push_valid = 1'b1;
                            if (instr[PP_BLK_BIT] && !push_ready) begin
                                instr_stall = 1'b1;
                            end else begin
                                next_isr     = ZERO_WORD;
                                next_isr_cnt = ZERO_CNT;
                            end
                        end
                    end
                end
                default: begin
                    next_isr = input_shift_reg;
                end
            endcase
        end
        if (osr_load_valid) begin
            next_osr     = osr_load_data;
            next_osr_cnt = ZERO_CNT;
        end
    end

    // ==========================================================
    // Input shift register
    always_ff @(posedge mclk) begin
        if (reset) begin
            input_shift_reg <= ZERO_WORD;
            in_shift_count  <= ZERO_CNT;
        end else begin
            input_shift_reg <= next_isr;
            in_shift_count  <= next_isr_cnt;
        end
    end

    // ==========================================================
    // Output shift register
    always_ff @(posedge mclk) begin
        if (reset) begin
            output_shift_reg <= ZERO_WORD;
            out_shift_count  <= FULL_CNT;
        end else begin
            output_shift_reg <= next_osr;
            out_shift_count  <= next_osr_cnt;
        end
    end

    // ==========================================================
    // Destination writes
    always_ff @(posedge mclk) begin
        if (reset) begin
            out_wr_data <= ZERO_WORD;
            out_dest_we <= '0;
        end else begin
            out_wr_data <= next_wr_data;
            out_dest_we <= next_dest_we;
        end
    end

    // ==========================================================
    // Receive buffer
    sfi_pair_buf #(
        .WIDTH (WORD_W),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .mclk      (mclk),
        .reset     (reset),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ==========================================================
    // Checks
    a_in_count_sat: assert property (@(posedge mclk) disable iff (reset)
        (instr_done && opc == OPC_IN && !auto_push_en) |=>
        in_shift_count == ((({1'b0, $past(in_shift_count)} + {1'b0, $past(n)}) > 7'h20) ?
                           FULL_CNT : $past(in_shift_count) + $past(n)))
        else $error("input count not saturated sum");
    a_autopush_clear: assert property (@(posedge mclk) disable iff (reset)
        (instr_done && opc == OPC_IN && push_valid) |=>
        (input_shift_reg == 32'h00000000 && in_shift_count == 6'h00))
        else $error("autopush left register set");
    a_push_stall_full: assert property (@(posedge mclk) disable iff (reset)
        (instr_valid && opc == OPC_PUSH_PULL && !instr[7] && instr[5] && !instr[6]
         && !push_ready) |-> instr_stall)
        else $error("blocking push did not stall");
    a_pull_stall_empty: assert property (@(posedge mclk) disable iff (reset)
        (instr_valid && opc == OPC_PUSH_PULL && instr[7] && instr[5] && !instr[6]
         && !tx_valid) |-> (instr_stall && !tx_ready))
        else $error("blocking pull did not stall");
    a_pull_copy_x: assert property (@(posedge mclk) disable iff (reset)
        (instr_done && opc == OPC_PUSH_PULL && instr[7] && !instr[6] && !tx_valid
         && !osr_load_valid) |=>
        (output_shift_reg == $past(scratch_x) && out_shift_count == 6'h00))
        else $error("empty pull did not copy X");
    a_out_upper_zero: assert property (@(posedge mclk) disable iff (reset)
        (instr_done && opc == OPC_OUT && instr[4:0] != 5'h00) |=>
        ((out_wr_data >> $past(instr[4:0])) == 32'h00000000))
        else $error("written word upper bits not zero");
    a_exec_next_cycle: assert property (@(posedge mclk) disable iff (reset)
        exec_retire |=>
        (out_dest_we == 8'h80) ##1 (out_dest_we[7] == $past(exec_retire)))
        else $error("execute strobe wrong");
    a_full_count_code: assert property (@(posedge mclk) disable iff (reset)
        (instr_done && opc == OPC_OUT && instr[4:0] == 5'h00 && !osr_load_valid
         && !pull_hit) |=> out_shift_count == 6'h20)
        else $error("zero count field not 32");
    a_push_discard: assert property (@(posedge mclk) disable iff (reset)
        (instr_valid && opc == OPC_PUSH_PULL && !instr[7] && !instr[6] && !instr[5])
        |-> !instr_stall ##1 input_shift_reg == 32'h00000000)
        else $error("non-blocking push stalled or kept data");
endmodule : sfi_exec_unit

// ### rtl/sfi_pair_buf.sv
`timescale 1ns/1ps
module sfi_pair_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int        PW        = $clog2(DEPTH);
    localparam logic [PW:0] FULL_FILL = (PW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      fill;
    logic             do_wr;
    logic             do_rd;

    // ==========================================================
    // Handshakes
    assign in_ready  = (fill != FULL_FILL);
    assign out_valid = (fill != '0);
    assign out_data  = mem[rd_ptr];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    // ==========================================================
    // Storage
    always_ff @(posedge mclk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // ==========================================================
    // Pointers and fill level
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                fill <= fill + 1'b1;
            end else if (do_rd && !do_wr) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule : sfi_pair_buf

// ### rtl/sfi_pkg.sv
package sfi_pkg;
    // ==========================================================
    // Widths
    localparam int          WORD_W    = 32;
    localparam int          INSTR_W   = 16;
    localparam logic [5:0]  FULL_CNT  = 6'h20;
    localparam logic [31:0] ALL_ONES  = 32'hFFFFFFFF;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam logic [5:0]  ZERO_CNT  = 6'h00;

    // ==========================================================
    // Instruction fields
    localparam int OPC_HI      = 15;
    localparam int OPC_LO      = 13;
    localparam int SEL_HI      = 7;
    localparam int SEL_LO      = 5;
    localparam int CNT_HI      = 4;
    localparam int CNT_LO      = 0;
    localparam int PP_PULL_BIT = 7;
    localparam int PP_IF_BIT   = 6;
    localparam int PP_BLK_BIT  = 5;

    // ==========================================================
    // Opcodes
    localparam logic [2:0] OPC_IN   = 3'h2;
    localparam logic [2:0] OPC_OUT  = 3'h3;
    localparam logic [2:0] OPC_PUSH_PULL = 3'h4;

    // ==========================================================
    // Input-shift sources
    localparam logic [2:0] SRC_PINS = 3'h0;
    localparam logic [2:0] SRC_X    = 3'h1;
    localparam logic [2:0] SRC_Y    = 3'h2;
    localparam logic [2:0] SRC_NULL = 3'h3;
    localparam logic [2:0] SRC_ISR  = 3'h6;
    localparam logic [2:0] SRC_OSR  = 3'h7;

    // ==========================================================
    // Output-shift destinations
    localparam logic [2:0] DST_PINS    = 3'h0;
    localparam logic [2:0] DST_X       = 3'h1;
    localparam logic [2:0] DST_Y       = 3'h2;
    localparam logic [2:0] DST_NULL    = 3'h3;
    localparam logic [2:0] DST_PIN_DIRECTIONS = 3'h4;
    localparam logic [2:0] DST_PC      = 3'h5;
    localparam logic [2:0] DST_ISR     = 3'h6;
    localparam logic [2:0] DST_EXEC    = 3'h7;
    localparam int         DST_NUM     = 8;

    // ==========================================================
    // Receive buffer
    localparam int BUF_DEPTH = 2;
endpackage : sfi_pkg
